// ### src/alc_line_config.sv
/*
 line configuration, received-timeout countdown and break send/detect.
 assumes control strobes come from logic on clk_sys; modem pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
`include "alc_regs.svh"
// Function
// RULE1 - timeout byte counts 0.1 second steps
// RULE2 - zero timeout byte disables monitoring
// RULE3 - all-ones timeout byte gives 25.5 seconds
// RULE4 - nonzero timeout keeps running countdown in status
// RULE5 - break bytes count 10 ms steps
// RULE6 - mode low digit selects break signals
// RULE7 - value 3 uses secondary pair, inverted polarity
// RULE8 - send break inverts selected output for duration
// RULE9 - break needs continuous inversion for detect duration
// RULE10 - break detection only sets status flag
// RULE11 - vector is 20 bytes, 18 accepted
// RULE12 - rate digit selects sixteen bit rates
// RULE13 - stop digit 1/2/3, zero illegal
// RULE14 - mode high digit selects duplex, null deletion
// RULE15 - char digit gives 5 to 8 bits
// RULE16 - parity digit: none, even, odd
// RULE17 - host uses 5/6 bits for shifting
// RULE18 - settings apply after load sequence completes
// RULE19 - host zeroes vector before setting values
// RULE20 - countdown reloads on start, turnaround, character
// RULE21 - flags clear on status read, config load
// RULE22 - ticks come from system clock prescalers
// RULE23 - countdown reaching zero records timeout status
module alc_line_config #(
    parameter int TMO_TICK_CYC = `ALC_TMO_STEP_NS / `ALC_CLK_NS,
    parameter int BRK_TICK_CYC = `ALC_BRK_STEP_NS / `ALC_CLK_NS
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cfgStart,
    input wire logic cfgValid,
    input wire logic [7:0] cfgData,
    input wire logic cfgDone,
    input wire logic statusRead,
    input wire logic rxStart,
    input wire logic lineTurn,
    input wire logic rxChar,
    input wire logic sendBreak,
    input wire logic txDataIn,
    input wire logic secRtsIn,
    input wire logic rxDataPin,
    input wire logic secLsdPin,
    output logic txDataPin,
    output logic secRtsPin,
    output logic rxDataSync,
    output logic breakActive,
    output alc_pkg::alc_line_cfg_t lineCfg,
    output alc_pkg::alc_status_t status
);
import alc_pkg::*;

////////////////////////////////////////////////////////////////
// vector load
logic [7:0] vec_q [0:19];
logic [4:0] vecIdx_q;
logic commit;
logic lenOk;
assign lenOk = (vecIdx_q == `ALC_VEC_LEN) || (vecIdx_q == `ALC_VEC_SHORT); // see RULE11
assign commit = cfgDone && lenOk; // see RULE18

always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        vecIdx_q <= 5'd0;
    end else if (cfgStart) begin
        vecIdx_q <= 5'd0;
    end else if (cfgValid && vecIdx_q < `ALC_VEC_LEN) begin
        vecIdx_q <= vecIdx_q + 5'd1;
    end
end

always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        for (int i = 0; i < 20; i++) begin
            vec_q[i] <= 8'h00;
        end
    end else if (cfgStart) begin
        for (int i = 0; i < 20; i++) begin
            vec_q[i] <= 8'h00;
        end
    end else if (cfgValid && vecIdx_q < `ALC_VEC_LEN) begin
        vec_q[vecIdx_q] <= cfgData;
    end
end

////////////////////////////////////////////////////////////////
// field decode
wire [7:0] rateByte = vec_q[`ALC_IDX_RATE];
wire [7:0] modeByte = vec_q[`ALC_IDX_MODE];
wire [7:0] charByte = vec_q[`ALC_IDX_CHAR];
logic [20:0] divSel;
always_comb begin
    unique case (rateByte[`ALC_LO]) // see RULE12
        4'h0: divSel = `ALC_DIV_0;
        4'h1: divSel = `ALC_DIV_1;
        4'h2: divSel = `ALC_DIV_2;
        4'h3: divSel = `ALC_DIV_3;
        4'h4: divSel = `ALC_DIV_4;
        4'h5: divSel = `ALC_DIV_5;
        4'h6: divSel = `ALC_DIV_6;
        4'h7: divSel = `ALC_DIV_7;
        4'h8: divSel = `ALC_DIV_8;
        4'h9: divSel = `ALC_DIV_9;
        4'ha: divSel = `ALC_DIV_A;
        4'hb: divSel = `ALC_DIV_B;
        4'hc: divSel = `ALC_DIV_C;
        4'hd: divSel = `ALC_DIV_D;
        4'he: divSel = `ALC_DIV_E;
        4'hf: divSel = `ALC_DIV_F;
    endcase
end
wire stopBad = rateByte[`ALC_HI] == `ALC_STOP_ILLEGAL; // see RULE13
wire [2:0] stopSel = stopBad ? `ALC_STOP_HALF_ONE : {1'b0, rateByte[5:4]} + 3'd1; // see RULE13
wire [3:0] bitsSel = `ALC_DATA_BITS_MIN + {2'b00, charByte[5:4]}; // see RULE15
wire parEn = charByte[0]; // see RULE16
wire parOdd = charByte[1]; // see RULE16
wire fullSel = modeByte[5]; // see RULE14
wire nullSel = modeByte[4]; // see RULE14
wire [1:0] brkSelRaw = modeByte[1:0]; // see RULE6

alc_line_cfg_t cfg_q;
logic [7:0] tmoIvl_q;
logic [7:0] btxIvl_q;
logic [7:0] bdetIvl_q;
always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        cfg_q <= '0;
        tmoIvl_q <= 8'h00;
        btxIvl_q <= 8'h00;
        bdetIvl_q <= 8'h00;
    end else if (commit) begin
        cfg_q <= {divSel, stopSel, fullSel, nullSel, bitsSel, parEn, parOdd, alc_brk_sel_t'(brkSelRaw)};
        tmoIvl_q <= vec_q[`ALC_IDX_TMO]; // see RULE1
        btxIvl_q <= vec_q[`ALC_IDX_BTX]; // see RULE5
        bdetIvl_q <= vec_q[`ALC_IDX_BDET]; // see RULE5
    end
end
assign lineCfg = cfg_q;

////////////////////////////////////////////////////////////////
// pin synchronisers
logic [1:0] rxSync_q;
logic [1:0] lsdSync_q;
always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        rxSync_q <= 2'b11;
        lsdSync_q <= 2'b11;
    end else begin
        rxSync_q <= {rxSync_q[0], rxDataPin};
        lsdSync_q <= {lsdSync_q[0], secLsdPin};
    end
end
assign rxDataSync = rxSync_q[1];

////////////////////////////////////////////////////////////////
// received timeout
logic [23:0] tmoPre_q;
logic [7:0] tmoCnt_q;
wire tmoEn = tmoIvl_q != 8'h00; // see RULE2
wire reload = rxStart || lineTurn || rxChar;
wire tmoTick = tmoPre_q == 24'(TMO_TICK_CYC - 1); // see RULE22
wire expire = tmoEn && !reload && tmoTick && tmoCnt_q == 8'h01; // see RULE23

always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        tmoPre_q <= 24'd0;
    end else if (reload || tmoTick || !tmoEn) begin
        tmoPre_q <= 24'd0;
    end else begin
        tmoPre_q <= tmoPre_q + 24'd1;
    end
end

always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        tmoCnt_q <= 8'h00;
    end else if (!tmoEn) begin
        tmoCnt_q <= 8'h00; // see RULE2
    end else if (reload) begin
        tmoCnt_q <= tmoIvl_q; // see RULE20
    end else if (tmoTick && tmoCnt_q != 8'h00) begin
        tmoCnt_q <= tmoCnt_q - 8'h01; // see RULE4
    end
end

////////////////////////////////////////////////////////////////
// break signalling
logic [23:0] btxPre_q;
logic [7:0] btxCnt_q;
wire brkSelOn = cfg_q.breakSel != ALC_BRK_OFF;
wire brkLevel = cfg_q.breakSel == ALC_BRK_SEC_INV; // see RULE7
wire btxTick = btxPre_q == 24'(BRK_TICK_CYC - 1); // see RULE22
wire btxGo = sendBreak && brkSelOn && btxIvl_q != 8'h00;
assign breakActive = btxCnt_q != 8'h00;

always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        btxPre_q <= 24'd0;
        btxCnt_q <= 8'h00;
    end else if (btxGo) begin
        btxPre_q <= 24'd0;
        btxCnt_q <= btxIvl_q; // see RULE8
    end else if (btxTick) begin
        btxPre_q <= 24'd0;
        btxCnt_q <= breakActive ? btxCnt_q - 8'h01 : 8'h00;
    end else begin
        btxPre_q <= btxPre_q + 24'd1;
    end
end

wire txBrk = breakActive && cfg_q.breakSel == ALC_BRK_DATA; // see RULE6
wire rtsBrk = breakActive && cfg_q.breakSel[1]; // see RULE7
logic txPin_q;
logic rtsPin_q;
always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        txPin_q <= 1'b1;
        rtsPin_q <= 1'b0;
    end else begin
        txPin_q <= txBrk ? 1'b0 : txDataIn; // see RULE8
        rtsPin_q <= rtsBrk ? brkLevel : secRtsIn; // see RULE8
    end
end
assign txDataPin = txPin_q;
assign secRtsPin = rtsPin_q;

wire detIn = cfg_q.breakSel == ALC_BRK_DATA ? rxSync_q[1] : lsdSync_q[1];
wire inverted = brkSelOn && detIn == brkLevel; // see RULE9
logic [23:0] detPre_q;
logic [7:0] detCnt_q;
logic detDone_q;
wire detTick = detPre_q == 24'(BRK_TICK_CYC - 1);
wire detHit = inverted && bdetIvl_q != 8'h00 && detCnt_q >= bdetIvl_q && !detDone_q; // see RULE9

always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        detPre_q <= 24'd0;
        detCnt_q <= 8'h00;
        detDone_q <= 1'b0;
    end else if (!inverted) begin
        detPre_q <= 24'd0; // see RULE9
        detCnt_q <= 8'h00;
        detDone_q <= 1'b0;
    end else begin
        detPre_q <= detTick ? 24'd0 : detPre_q + 24'd1;
        detCnt_q <= (detTick && detCnt_q != 8'hff) ? detCnt_q + 8'h01 : detCnt_q;
        detDone_q <= detDone_q || detHit;
    end
end

////////////////////////////////////////////////////////////////
// status flags, set wins over clear
logic brkFlag_q;
logic tmoFlag_q;
logic illFlag_q;
logic lenFlag_q;
wire flagClr = statusRead || commit; // see RULE21
always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
        brkFlag_q <= 1'b0;
        tmoFlag_q <= 1'b0;
        illFlag_q <= 1'b0;
        lenFlag_q <= 1'b0;
    end else begin
        brkFlag_q <= detHit || (brkFlag_q && !flagClr); // see RULE10
        tmoFlag_q <= expire || (tmoFlag_q && !flagClr); // see RULE23
        illFlag_q <= (commit && stopBad) || (illFlag_q && !flagClr); // see RULE13
        lenFlag_q <= (cfgDone && !lenOk) || (lenFlag_q && !flagClr); // see RULE11
    end
end
assign status = {illFlag_q, lenFlag_q, tmoFlag_q, brkFlag_q, tmoCnt_q};

////////////////////////////////////////////////////////////////
// checks
property p_tmo_off;
    @(posedge clk_sys) disable iff (reset)
    (tmoIvl_q == 8'h00) |=> (tmoCnt_q == 8'h00);
endproperty
a_tmo_off: assert property (p_tmo_off) else $error("countdown runs while disabled"); // see RULE2

property p_reload;
    @(posedge clk_sys) disable iff (reset)
    (reload && tmoEn && !commit) |=> (tmoCnt_q == $past(tmoIvl_q));
endproperty
a_reload: assert property (p_reload) else $error("countdown not reloaded"); // see RULE20

property p_count;
    @(posedge clk_sys) disable iff (reset)
    (tmoTick && tmoEn && !reload && tmoCnt_q != 8'h00 && !commit) |=> (tmoCnt_q == $past(tmoCnt_q) - 8'h01);
endproperty
a_count: assert property (p_count) else $error("countdown step wrong"); // see RULE4

property p_expire;
    @(posedge clk_sys) disable iff (reset)
    expire |=> (tmoFlag_q && tmoCnt_q == 8'h00);
endproperty
a_expire: assert property (p_expire) else $error("timeout not recorded"); // see RULE23

property p_brk_tx;
    @(posedge clk_sys) disable iff (reset)
    (btxGo && cfg_q.breakSel == ALC_BRK_DATA && !commit) |=> ##1 (txDataPin == 1'b0);
endproperty
a_brk_tx: assert property (p_brk_tx) else $error("break not driven"); // see RULE8

property p_brk_pol;
    @(posedge clk_sys) disable iff (reset)
    (rtsBrk) |=> (secRtsPin == $past(brkLevel));
endproperty
a_brk_pol: assert property (p_brk_pol) else $error("break polarity wrong"); // see RULE7

property p_brk_det;
    @(posedge clk_sys) disable iff (reset)
    ($rose(brkFlag_q)) |-> ($past(inverted) && $past(detCnt_q) >= $past(bdetIvl_q));
endproperty
a_brk_det: assert property (p_brk_det) else $error("break flag without long inversion"); // see RULE9

property p_clr;
    @(posedge clk_sys) disable iff (reset)
    (statusRead && !detHit) |=> !brkFlag_q;
endproperty
a_clr: assert property (p_clr) else $error("flag survived status read"); // see RULE21

property p_stop_ill;
    @(posedge clk_sys) disable iff (reset)
    (commit && stopBad) |=> (illFlag_q && lineCfg.stopHalves == `ALC_STOP_HALF_ONE);
endproperty
a_stop_ill: assert property (p_stop_ill) else $error("illegal stop digit missed"); // see RULE13

property p_bits;
    @(posedge clk_sys) disable iff (reset)
    commit |=> (lineCfg.dataBits == `ALC_DATA_BITS_MIN + {2'b00, $past(charByte[5:4])});
endproperty
a_bits: assert property (p_bits) else $error("data length wrong"); // see RULE15

endmodule // alc_line_config
`default_nettype wire

// ### src/alc_regs.svh
/*
 line configuration constants: vector layout, field positions, timing figures.
 assumes a 100 MHz system clock.
*/
`ifndef ALC_REGS_SVH
`define ALC_REGS_SVH
`define ALC_VEC_LEN 5'd20
`define ALC_VEC_SHORT 5'd18
`define ALC_IDX_RATE 5'd0
`define ALC_IDX_MODE 5'd1
`define ALC_IDX_CHAR 5'd2
`define ALC_IDX_TMO 5'd4
`define ALC_IDX_BTX 5'd8
`define ALC_IDX_BDET 5'd9
`define ALC_HI 7:4
`define ALC_LO 3:0
`define ALC_CLK_NS 10
`define ALC_TMO_STEP_NS 100000000
`define ALC_BRK_STEP_NS 10000000
`define ALC_DATA_BITS_MIN 4'd5
`define ALC_STOP_ILLEGAL 4'h0
`define ALC_STOP_HALF_ONE 3'd2
`define ALC_DIV_0 21'd2000000
`define ALC_DIV_1 21'd1333333
`define ALC_DIV_2 21'd1000000
`define ALC_DIV_3 21'd909090
`define ALC_DIV_4 21'd743494
`define ALC_DIV_5 21'd666666
`define ALC_DIV_6 21'd500000
`define ALC_DIV_7 21'd333333
`define ALC_DIV_8 21'd166666
`define ALC_DIV_9 21'd83333
`define ALC_DIV_A 21'd55555
`define ALC_DIV_B 21'd41666
`define ALC_DIV_C 21'd27777
`define ALC_DIV_D 21'd20833
`define ALC_DIV_E 21'd13888
`define ALC_DIV_F 21'd10416
`endif

// ### src/alc_pkg.sv
/*
 types shared by the line configuration block.
 assumes alc_regs.svh for the numeric constants.
*/
package alc_pkg;
typedef enum logic [1:0] {
    ALC_BRK_OFF = 2'b00,
    ALC_BRK_DATA = 2'b01,
    ALC_BRK_SEC = 2'b10,
    ALC_BRK_SEC_INV = 2'b11
} alc_brk_sel_t;
typedef struct packed {
    logic [20:0] bitDiv;
    logic [2:0] stopHalves;
    logic fullDuplex;
    logic nullDelete;
    logic [3:0] dataBits;
    logic parityEn;
    logic parityOdd;
    alc_brk_sel_t breakSel;
} alc_line_cfg_t;
typedef struct packed {
    logic cfgIllegal;
    logic cfgLenErr;
    logic rxTimeout;
    logic breakRcvd;
    logic [7:0] timeoutCount;
} alc_status_t;
endpackage

// ### verification/alc_modem_model.sv
/*
 modem model: loops transmitted data back and raises break levels on request.
 assumes the bench sets the break mode and the break request.
*/
`timescale 1ns/10ps
`default_nettype none
module alc_modem_model (
    input wire logic [1:0] brkMode,
    input wire logic brkOn,
    input wire logic txDataPin,
    input wire logic secRtsPin,
    output logic rxDataPin,
    output logic secLsdPin
);
    // data break holds received data low, secondary break inverts detect
    always_comb begin
        rxDataPin = txDataPin && !(brkOn && brkMode == 2'd1);
        secLsdPin = (brkMode == 2'd3) ? brkOn : !brkOn;
    end
endmodule // alc_modem_model
`default_nettype wire

// ### verification/async_line_config_break_timeout_tb.sv
/*
 bench for line configuration: vector load, timeout countdown, break send and detect.
 assumes alc_modem_model on the pins and a 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "alc_regs.svh"
module async_line_config_break_timeout_tb;
    import alc_pkg::*;
    localparam int TMO = 10;
    localparam int BRK = 8;
    logic clk_sys = 0;
    logic reset = 1;
    logic cfgStart = 0;
    logic cfgValid = 0;
    logic [7:0] cfgData = 8'h00;
    logic cfgDone = 0;
    logic [4:0] pul = 5'h00;
    logic txDataIn = 1;
    logic secRtsIn = 0;
    logic [1:0] brkMode = 2'h0;
    logic brkOn = 0;
    logic txDataPin, secRtsPin, rxDataSync, breakActive, rxDataPin, secLsdPin;
    alc_line_cfg_t lineCfg;
    alc_line_cfg_t expC;
    alc_status_t status;
    logic [20:0] divTab [16] = '{`ALC_DIV_0, `ALC_DIV_1, `ALC_DIV_2, `ALC_DIV_3, `ALC_DIV_4, `ALC_DIV_5,
        `ALC_DIV_6, `ALC_DIV_7, `ALC_DIV_8, `ALC_DIV_9, `ALC_DIV_A, `ALC_DIV_B, `ALC_DIV_C, `ALC_DIV_D,
        `ALC_DIV_E, `ALC_DIV_F};
    logic [7:0] vec [20];
    int n_fail = 0;
    int check_count = 0;
    int n;
    always #5 clk_sys = ~clk_sys;
    alc_line_config #(.TMO_TICK_CYC(TMO), .BRK_TICK_CYC(BRK)) i_dut (.clk_sys(clk_sys), .reset(reset),
        .cfgStart(cfgStart), .cfgValid(cfgValid), .cfgData(cfgData), .cfgDone(cfgDone),
        .statusRead(pul[3]), .rxStart(pul[0]), .lineTurn(pul[1]), .rxChar(pul[2]),
        .sendBreak(pul[4]), .txDataIn(txDataIn), .secRtsIn(secRtsIn), .rxDataPin(rxDataPin),
        .secLsdPin(secLsdPin), .txDataPin(txDataPin), .secRtsPin(secRtsPin), .rxDataSync(rxDataSync),
        .breakActive(breakActive), .lineCfg(lineCfg), .status(status));
    alc_modem_model i_modem (.brkMode(brkMode), .brkOn(brkOn), .txDataPin(txDataPin),
        .secRtsPin(secRtsPin), .rxDataPin(rxDataPin), .secLsdPin(secLsdPin));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
        if (what == "wait" && got !== exp) begin
            end_of_test();
        end
    endtask
    task automatic chkCfg(input alc_line_cfg_t exp, input alc_line_cfg_t got);
        if (!exp.parityEn) begin
            exp.parityOdd = 1'b0;
            got.parityOdd = 1'b0;
        end
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR lineCfg expected %0h seen %0h", exp, got);
        end
    endtask
    // expected line settings from the first three vector bytes
    function automatic alc_line_cfg_t cfgOf(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        alc_line_cfg_t c;
        c.bitDiv = divTab[b1[3:0]];
        c.stopHalves = (b1[5:4] == 2'd0) ? 3'd2 : {1'b0, b1[5:4]} + 3'd1;
        c.fullDuplex = b2[5];
        c.nullDelete = b2[4];
        c.dataBits = 4'd5 + {2'b00, b3[5:4]};
        c.parityEn = b3[0];
        c.parityOdd = b3[1] & b3[0];
        c.breakSel = alc_brk_sel_t'(b2[1:0]);
        return c;
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic pulse(input int k);
        pul[k] = 1'b1;
        cyc(1);
        pul[k] = 1'b0;
        cyc(1);
    endtask
    task automatic loadVec(input int len);
        cfgStart = 1'b1;
        cyc(1);
        cfgStart = 1'b0;
        for (int i = 0; i < len; i++) begin
            cfgValid = 1'b1;
            cfgData = vec[i];
            cyc(1);
        end
        cfgValid = 1'b0;
        cfgDone = 1'b1;
        cyc(1);
        cfgDone = 1'b0;
        cyc(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h5d663f8a));
        cyc(19);
        chkCfg('0, lineCfg);
        chkVal("status", 0, status);
        chkVal("pins", 3'b101, {txDataPin, secRtsPin, rxDataSync});
        cyc(1);
        reset = 1'b0;
        cyc(1);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            foreach (vec[k]) vec[k] = 8'($urandom);
            vec[0] = {2'b00, 2'(i), 4'(i)};
            vec[1] = {2'b00, 2'(i >> 2), 2'b00, 2'(i)};
            vec[2] = {2'b00, 2'(i), 2'b00, 2'(i >> 2)};
            loadVec(i[0] ? 18 : 20);
            chkCfg(cfgOf(vec[0], vec[1], vec[2]), lineCfg);
            chkVal("cfgIllegal", (i % 4) == 0, status.cfgIllegal);
        end
        expC = lineCfg;
        vec[0] = 8'h17;
        loadVec(19);
        chkVal("cfgLenErr", 1, status.cfgLenErr);
        chkCfg(cfgOf(vec[0], vec[1], vec[2]) == lineCfg ? 'x : expC, lineCfg);
        pulse(3);
        chkVal("cfgLenErr", 0, status.cfgLenErr);
        $display("test config done");
        vec = '{default: 8'h00};
        vec[0] = 8'h17;
        vec[2] = 8'h10;
        vec[6] = 8'h5b;
        vec[7] = 8'h5d;
        vec[4] = 8'h03;
        loadVec(20);
        for (int k = 0; k < 3; k++) begin
            pulse(k);
            chkVal("timeoutCount", 3, status.timeoutCount);
            cyc(12);
            chkVal("rxTimeout", 0, status.rxTimeout);
        end
        n = 0;
        while (status.rxTimeout !== 1'b1 && n < 100) begin
            n++;
            cyc(1);
        end
        chkVal("wait", 1, n < 100);
        chkVal("tmoCycles", 1, n >= 3 * TMO - 13 && n <= 3 * TMO - 11);
        chkVal("timeoutCount", 0, status.timeoutCount);
        pulse(3);
        chkVal("rxTimeout", 0, status.rxTimeout);
        vec[4] = 8'hff;
        loadVec(20);
        pulse(0);
        chkVal("timeoutCount", 8'hff, status.timeoutCount);
        vec[4] = 8'h00;
        loadVec(20);
        pulse(0);
        cyc(40);
        chkVal("rxTimeout", 0, {status.rxTimeout, status.timeoutCount});
        $display("test timeout done");
        for (int m = 0; m < 4; m++) begin
            vec[1] = 8'(m);
            vec[8] = 8'h02;
            vec[9] = 8'h03;
            brkMode = 2'(m);
            secRtsIn = (m != 3);
            loadVec(20);
            brkOn = 1'b1;
            cyc(2 * BRK);
            brkOn = 1'b0;
            cyc(4);
            chkVal("breakRcvd", 0, status.breakRcvd);
            brkOn = 1'b1;
            cyc(5 * BRK);
            brkOn = 1'b0;
            cyc(4);
            chkVal("breakRcvd", m != 0, status.breakRcvd);
            chkCfg(cfgOf(vec[0], vec[1], vec[2]), lineCfg);
            pul[4] = 1'b1;
            cyc(1);
            pul[4] = 1'b0;
            n = 0;
            while (breakActive === 1'b1 && n < 100) begin
                n++;
                if (n == 4) begin
                    chkVal("breakPins", {m != 1, m != 2}, {txDataPin, secRtsPin});
                    chkVal("rxDataSync", m != 1, rxDataSync);
                end
                cyc(1);
            end
            chkVal("breakCycles", m == 0 ? 0 : 2 * BRK, n);
            cyc(4);
            chkVal("idlePins", {1'b1, m != 3}, {txDataPin, secRtsPin});
        end
        $display("test break done");
        end_of_test();
    end
endmodule // async_line_config_break_timeout_tb
`default_nettype wire
